/* File: tmr_consts.vh */
// Register indices, field positions, reset values and timing counts of the timer block
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define TMR_IDX_TCTL 10'h088
`define TMR_IDX_MODE 10'h089
`define TMR_IDX_TL0 10'h08A
`define TMR_IDX_TL1 10'h08B
`define TMR_IDX_TH0 10'h08C
`define TMR_IDX_TH1 10'h08D
`define TMR_IDX_ISTAT 10'h0A0
`define TMR_IDX_IMASK 10'h0A1

// Control register field positions
`define TMR_OVF1_BIT 7
`define TMR_RUN1_BIT 6
`define TMR_OVF0_BIT 5
`define TMR_RUN0_BIT 4
`define TMR_XF1_BIT 3
`define TMR_XT1_BIT 2
`define TMR_XF0_BIT 1
`define TMR_XT0_BIT 0

// Mode register field positions
`define TMR_GATE1_BIT 7
`define TMR_CT1_BIT 6
`define TMR_MODE1_HI 5
`define TMR_MODE1_LO 4
`define TMR_GATE0_BIT 3
`define TMR_CT0_BIT 2
`define TMR_MODE0_HI 1
`define TMR_MODE0_LO 0

// Mode encodings
`define TMR_MODE_13BIT 2'h0
`define TMR_MODE_16BIT 2'h1
`define TMR_MODE_RELOAD 2'h2
`define TMR_MODE_SPLIT 2'h3

// Interrupt status bit positions
`define TMR_EV_OVF0 0
`define TMR_EV_OVF1 1
`define TMR_EV_XF0 2
`define TMR_EV_XF1 3

// Reset values
`define TMR_RST_BYTE 8'h00
`define TMR_RST_EV 4'h0

// Internal count clock: one tick per this many core clocks
`define TMR_TICK_DIV 4'hC

`endif

/* File: tmr_pin_sync.v */
// Two-flop synchroniser with falling-edge detector for one input pin
module tmr_pin_sync (
    input wire pclk,
    input wire presetn,
    input wire pin,
    output wire level,
    output wire fall
);
    reg meta;
    reg sync;
    reg prev;

    // Idle-high reset so release never fakes a falling edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // Level is the second stage, fall compares it with the third; one pulse per edge
    assign level = sync;
    assign fall = prev & ~sync;
endmodule

/* File: tmr_tick_div.v */
// Divider that makes the internal count-clock enable pulse
`include "tmr_consts.vh"
module tmr_tick_div (
    input wire pclk,
    input wire presetn,
    output reg tick
);
    reg [3:0] count;

    // Free running, one-cycle pulse every TMR_TICK_DIV clocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            tick <= 1'b0;
        end else if (count == `TMR_TICK_DIV - 4'h1) begin
            count <= 4'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 4'h1;
            tick <= 1'b0;
        end
    end
endmodule

/* File: tmr_top.v */
// Timer zero/one and external interrupt control with APB register access
//
// Function
// - Timer one overflow sets its flag unless timer zero is in split mode, vectoring clears it, software may set or clear it.
// - Timer zero overflow sets its flag, vectoring clears it, software may set or clear it.
// - The timer one run bit turns timer one on when one and off when zero.
// - The timer zero run bit turns timer zero on when one and off when zero.
// - Interrupt one flag sets on fall or low level, clears at service in edge mode, follows pin in level mode.
// - Interrupt zero flag sets on fall or low level, clears at service in edge mode, follows pin in level mode.
// - Interrupt one type bit selects falling edge when one and low level when zero.
// - Interrupt zero type bit selects falling edge when one and low level when zero.
// - The control register holds overflow flag and run bit per timer, then interrupt flag and type bit per interrupt, one above zero.
// - The mode register holds a four-bit group per timer, timer one above, timer zero below.
// - Timer one gating restricts counting to times its interrupt pin is high and it runs.
// - Timer one counter select picks count-pin falling edges over the internal clock.
// - Timer zero gating and counter select act like timer one's on its own pins.
// - Mode field gives a 13-bit timer, a 16-bit timer or an 8-bit auto-reload timer.
// - In split mode timer zero's bytes run as two 8-bit timers; timer one stops only when its own mode field is split.
`include "tmr_consts.vh"

module tmr_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ext_irq_zero_pin,
    input wire ext_irq_one_pin,
    input wire timer_zero_count_pin,
    input wire timer_one_count_pin,
    input wire ack_timer_zero,
    input wire ack_timer_one,
    input wire ack_ext_irq_zero,
    input wire ack_ext_irq_one,
    output reg timer_zero_overflow_flag_out,
    output reg timer_one_overflow_flag_out,
    output reg ext_irq_zero_flag_out,
    output reg ext_irq_one_flag_out,
    output reg irq
);
    // Control register fields and mode register
    reg timer_one_overflow_flag;
    reg timer_one_run;
    reg timer_zero_overflow_flag;
    reg timer_zero_run;
    reg ext_irq_one_flag;
    reg ext_irq_one_type_select;
    reg ext_irq_zero_flag;
    reg ext_irq_zero_type_select;
    reg [7:0] timer_mode_control;
    // Count registers: low and high byte per timer; event status and mask
    reg [7:0] tl0;
    reg [7:0] th0;
    reg [7:0] tl1;
    reg [7:0] th1;
    reg [3:0] ev_stat;
    reg [3:0] ev_mask;

    wire [3:0] pin_raw;
    wire [3:0] pin_lvl;
    wire [3:0] pin_fall;
    wire tick;

    // Synchronise pins: 0 irq zero, 1 irq one, 2 count zero, 3 count one
    assign pin_raw = {timer_one_count_pin, timer_zero_count_pin,
                      ext_irq_one_pin, ext_irq_zero_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            tmr_pin_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pin_raw[gi]),
                .level(pin_lvl[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    tmr_tick_div u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // Bus decode
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire [9:0] idx = paddr[11:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire [7:0] wb = pwdata[7:0];
    wire wr_tctl = wr & aligned & (idx == `TMR_IDX_TCTL);
    wire wr_mode = wr & aligned & (idx == `TMR_IDX_MODE);
    wire wr_tl0 = wr & aligned & (idx == `TMR_IDX_TL0);
    wire wr_tl1 = wr & aligned & (idx == `TMR_IDX_TL1);
    wire wr_th0 = wr & aligned & (idx == `TMR_IDX_TH0);
    wire wr_th1 = wr & aligned & (idx == `TMR_IDX_TH1);
    wire wr_stat = wr & aligned & (idx == `TMR_IDX_ISTAT);
    wire wr_mask = wr & aligned & (idx == `TMR_IDX_IMASK);

    wire [1:0] mode0 = timer_mode_control[`TMR_MODE0_HI:`TMR_MODE0_LO];
    wire [1:0] mode1 = timer_mode_control[`TMR_MODE1_HI:`TMR_MODE1_LO];

    // Count enables: run bit, optional gate by irq pin, clock or pin edge
    wire src0 = timer_mode_control[`TMR_CT0_BIT] ? pin_fall[2] : tick;
    wire src1 = timer_mode_control[`TMR_CT1_BIT] ? pin_fall[3] : tick;
    wire gate_ok0 = ~timer_mode_control[`TMR_GATE0_BIT] | pin_lvl[0];
    wire gate_ok1 = ~timer_mode_control[`TMR_GATE1_BIT] | pin_lvl[1];
    wire en0 = timer_zero_run & gate_ok0 & src0;
    wire en1 = timer_one_run & gate_ok1 & src1 & (mode1 != `TMR_MODE_SPLIT);
    // Split mode: high byte of timer zero is a plain timer on timer one's run bit
    wire en0h = (mode0 == `TMR_MODE_SPLIT) & timer_one_run & tick;

    // One count step; returns overflow above the new 16-bit value
    function [16:0] tmr_step;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        reg [5:0] pre;
        reg [8:0] hi9;
        reg [8:0] lo9;
        reg [16:0] full;
        begin
            pre = {1'b0, lo[4:0]} + 6'h01;
            hi9 = {1'b0, hi} + 9'h001;
            lo9 = {1'b0, lo} + 9'h001;
            full = {1'b0, hi, lo} + 17'h0_0001;
            case (mode)
                `TMR_MODE_13BIT: begin
                    // Low five bits prescale the high byte
                    if (pre[5])
                        tmr_step = {hi9[8], hi9[7:0], lo[7:5], 5'h00};
                    else
                        tmr_step = {1'b0, hi, lo[7:5], pre[4:0]};
                end
                `TMR_MODE_16BIT: begin
                    tmr_step = full;
                end
                `TMR_MODE_RELOAD: begin
                    // Low byte reloads from the high byte on wrap
                    if (lo9[8])
                        tmr_step = {1'b1, hi, hi};
                    else
                        tmr_step = {1'b0, hi, lo9[7:0]};
                end
                default: begin
                    // Split: low byte only; high byte counted apart
                    tmr_step = {lo9[8], hi, lo9[7:0]};
                end
            endcase
        end
    endfunction

    wire [16:0] step0 = tmr_step(mode0, tl0, th0);
    wire [16:0] step1 = tmr_step(mode1, tl1, th1);
    wire [8:0] th0_inc = {1'b0, th0} + 9'h001;
    wire ovf0 = en0 & step0[16];
    wire ovf0h = en0h & th0_inc[8];
    // Timer one overflow only raises its flag when split mode does not own it
    wire ovf1 = en1 & step1[16] & (mode0 != `TMR_MODE_SPLIT);
    wire set_ovf0 = ovf0;
    wire set_ovf1 = ovf1 | ovf0h;

    // Count registers; a software write beats a count in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tl0 <= `TMR_RST_BYTE;
            th0 <= `TMR_RST_BYTE;
            tl1 <= `TMR_RST_BYTE;
            th1 <= `TMR_RST_BYTE;
        end else begin
            if (wr_tl0)
                tl0 <= wb;
            else if (en0)
                tl0 <= step0[7:0];
            if (wr_th0)
                th0 <= wb;
            else if (en0h)
                th0 <= th0_inc[7:0];
            else if (en0 & (mode0 != `TMR_MODE_SPLIT))
                th0 <= step0[15:8];
            if (wr_tl1)
                tl1 <= wb;
            else if (en1)
                tl1 <= step1[7:0];
            if (wr_th1)
                th1 <= wb;
            else if (en1)
                th1 <= step1[15:8];
        end
    end

    // Flag next values: hardware set wins over vector or software clear
    reg next_ovf0;
    reg next_ovf1;
    reg next_xf0;
    reg next_xf1;
    always @* begin
        next_ovf0 = timer_zero_overflow_flag;
        next_ovf1 = timer_one_overflow_flag;
        next_xf0 = ext_irq_zero_flag;
        next_xf1 = ext_irq_one_flag;
        if (ack_timer_zero)
            next_ovf0 = 1'b0;
        if (ack_timer_one)
            next_ovf1 = 1'b0;
        if (ack_ext_irq_zero & ext_irq_zero_type_select)
            next_xf0 = 1'b0;
        if (ack_ext_irq_one & ext_irq_one_type_select)
            next_xf1 = 1'b0;
        if (wr_tctl) begin
            next_ovf0 = wb[`TMR_OVF0_BIT];
            next_ovf1 = wb[`TMR_OVF1_BIT];
            next_xf0 = wb[`TMR_XF0_BIT];
            next_xf1 = wb[`TMR_XF1_BIT];
        end
        if (set_ovf0)
            next_ovf0 = 1'b1;
        if (set_ovf1)
            next_ovf1 = 1'b1;
        // Edge mode latches a fall; level mode tracks the pin directly
        if (ext_irq_zero_type_select)
            next_xf0 = next_xf0 | pin_fall[0];
        else
            next_xf0 = ~pin_lvl[0];
        if (ext_irq_one_type_select)
            next_xf1 = next_xf1 | pin_fall[1];
        else
            next_xf1 = ~pin_lvl[1];
    end

    // Control and mode registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_overflow_flag <= 1'b0;
            timer_one_run <= 1'b0;
            timer_zero_overflow_flag <= 1'b0;
            timer_zero_run <= 1'b0;
            ext_irq_one_flag <= 1'b0;
            ext_irq_one_type_select <= 1'b0;
            ext_irq_zero_flag <= 1'b0;
            ext_irq_zero_type_select <= 1'b0;
            timer_mode_control <= `TMR_RST_BYTE;
        end else begin
            timer_one_overflow_flag <= next_ovf1;
            timer_zero_overflow_flag <= next_ovf0;
            ext_irq_one_flag <= next_xf1;
            ext_irq_zero_flag <= next_xf0;
            if (wr_tctl) begin
                timer_one_run <= wb[`TMR_RUN1_BIT];
                timer_zero_run <= wb[`TMR_RUN0_BIT];
                ext_irq_one_type_select <= wb[`TMR_XT1_BIT];
                ext_irq_zero_type_select <= wb[`TMR_XT0_BIT];
            end
            if (wr_mode)
                timer_mode_control <= wb;
        end
    end

    // Events are each overflow set pulse and the rising of each interrupt flag; sticky until written with a one
    wire [3:0] ev_now = {next_xf1 & ~ext_irq_one_flag, next_xf0 & ~ext_irq_zero_flag,
                         set_ovf1, set_ovf0};
    wire [3:0] w1c = wr_stat ? pwdata[3:0] : 4'h0;
    wire [3:0] next_stat = (ev_stat & ~w1c) | ev_now;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat <= `TMR_RST_EV;
            ev_mask <= `TMR_RST_EV;
            irq <= 1'b0;
            timer_zero_overflow_flag_out <= 1'b0;
            timer_one_overflow_flag_out <= 1'b0;
            ext_irq_zero_flag_out <= 1'b0;
            ext_irq_one_flag_out <= 1'b0;
        end else begin
            ev_stat <= next_stat;
            if (wr_mask)
                ev_mask <= pwdata[3:0];
            irq <= |(next_stat & (wr_mask ? pwdata[3:0] : ev_mask));
            // Flag copies for the service sequencer, same timing as the register
            timer_zero_overflow_flag_out <= next_ovf0;
            timer_one_overflow_flag_out <= next_ovf1;
            ext_irq_zero_flag_out <= next_xf0;
            ext_irq_one_flag_out <= next_xf1;
        end
    end

    // Read mux, evaluated in the setup cycle
    reg [7:0] rd_byte;
    reg rd_hit;
    always @* begin
        rd_byte = 8'h00;
        rd_hit = aligned;
        case (idx)
            `TMR_IDX_TCTL: rd_byte = {timer_one_overflow_flag, timer_one_run,
                                      timer_zero_overflow_flag, timer_zero_run,
                                      ext_irq_one_flag, ext_irq_one_type_select,
                                      ext_irq_zero_flag, ext_irq_zero_type_select};
            `TMR_IDX_MODE: rd_byte = timer_mode_control;
            `TMR_IDX_TL0: rd_byte = tl0;
            `TMR_IDX_TL1: rd_byte = tl1;
            `TMR_IDX_TH0: rd_byte = th0;
            `TMR_IDX_TH1: rd_byte = th1;
            `TMR_IDX_ISTAT: rd_byte = {4'h0, ev_stat};
            `TMR_IDX_IMASK: rd_byte = {4'h0, ev_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // Zero-wait slave: answer registered at the setup edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel & ~penable & ~pwrite & rd_hit)
                prdata <= {24'h00_0000, rd_byte};
            else
                prdata <= 32'h0000_0000;
        end
    end
endmodule

/* File: tmr_pin_model.sv */
// Behavioural model of the external interrupt and count input pins
module tmr_pin_model (
    input logic pclk,
    output logic ext_irq_zero_pin,
    output logic ext_irq_one_pin,
    output logic timer_zero_count_pin,
    output logic timer_one_count_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pin = 4'hF;
    // Pins idle high, as the block assumes at reset release
    assign {timer_one_count_pin, timer_zero_count_pin, ext_irq_one_pin, ext_irq_zero_pin} = pin;
    // Hold each level two clocks, shorter pulses may be missed
    task automatic drive(input int idx, input logic v);
        @(posedge pclk);
        pin[idx] <= v;
        repeat (2) @(posedge pclk);
    endtask
    // Full low-high pulses so every falling edge is seen once
    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            drive(idx, 1'b0);
            drive(idx, 1'b1);
        end
    endtask
endmodule

/* File: tmr_checker_assertions.sv */
// Checker for the timer block's bus, flag and interrupt behaviour
module tmr_checker (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic ext_irq_zero_pin,
    input logic ext_irq_one_pin,
    input logic ack_timer_zero,
    input logic ack_timer_one,
    input logic timer_zero_overflow_flag_out,
    input logic timer_one_overflow_flag_out,
    input logic ext_irq_zero_flag_out,
    input logic ext_irq_one_flag_out,
    input logic irq
);
    logic wr_ok;
    logic [1:0] it_q;
    logic [1:0] tr_q;
    logic [3:0] mask_q;
    // Accepted register write
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    // Shadow of type, run and mask bits: which flag rule applies depends on them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            it_q <= 2'h0;
            tr_q <= 2'h0;
            mask_q <= 4'h0;
        end else if (wr_ok && paddr == 12'h220) begin
            it_q <= {pwdata[2], pwdata[0]};
            tr_q <= {pwdata[6], pwdata[4]};
        end else if (wr_ok && paddr == 12'h284) begin
            mask_q <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_bus_answers: assert property (s_setup |=> s_access) else $error("no ready after setup");
    a_ready_single: assert property (s_access |=> !pready) else $error("ready held");
    a_bad_addr: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned not refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("rdata idle");
    a_zero_sw_set: assert property (wr_ok && paddr == 12'h220 && pwdata[5] && !ack_timer_zero
        |=> ##[0:1] timer_zero_overflow_flag_out) else $error("ovf0 not set");
    a_zero_ack_clear: assert property (ack_timer_zero && !tr_q[0] && !$past(tr_q[0], 2)
        |=> !timer_zero_overflow_flag_out) else $error("ovf0 not cleared");
    a_one_ack_clear: assert property (ack_timer_one && !tr_q[1] && !$past(tr_q[1], 2)
        |=> !timer_one_overflow_flag_out) else $error("ovf1 not cleared");
    a_zero_level_follow: assert property (!it_q[0] && !$past(it_q[0], 4)
        |-> ext_irq_zero_flag_out == !$past(ext_irq_zero_pin, 3)) else $error("xf0 lag");
    a_one_edge_set: assert property (it_q[1] && $fell(ext_irq_one_pin)
        |-> ##[1:4] ext_irq_one_flag_out) else $error("xf1 edge missed");
    a_irq_masked_off: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
        else $error("irq while masked");
endmodule

bind tmr_top tmr_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_irq_zero_pin, .ext_irq_one_pin, .ack_timer_zero,
    .ack_timer_one, .timer_zero_overflow_flag_out, .timer_one_overflow_flag_out,
    .ext_irq_zero_flag_out, .ext_irq_one_flag_out, .irq);

/* File: test_timer01_and_ext_irq_control.sv */
// Self-checking testbench for the timer block
`include "tmr_consts.vh"
module test_timer01_and_ext_irq_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTL = {`TMR_IDX_TCTL, 2'b00};
    localparam logic [11:0] A_MODE = {`TMR_IDX_MODE, 2'b00};
    localparam logic [11:0] A_TL0 = {`TMR_IDX_TL0, 2'b00};
    localparam logic [11:0] A_TL1 = {`TMR_IDX_TL1, 2'b00};
    localparam logic [11:0] A_TH0 = {`TMR_IDX_TH0, 2'b00};
    localparam logic [11:0] A_TH1 = {`TMR_IDX_TH1, 2'b00};
    localparam logic [11:0] A_STAT = {`TMR_IDX_ISTAT, 2'b00};
    localparam logic [11:0] A_MASK = {`TMR_IDX_IMASK, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] ack = 4'h0;
    logic [31:0] q;
    logic e;
    logic [7:0] tl_tab [3] = '{8'h1E, 8'hFE, 8'hFE};
    wire [31:0] prdata;
    wire pready, pslverr, irq, i0, i1, c0, c1;
    wire [3:0] fl;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;
    tmr_pin_model pins (.pclk(pclk), .ext_irq_zero_pin(i0), .ext_irq_one_pin(i1),
        .timer_zero_count_pin(c0), .timer_one_count_pin(c1));
    tmr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_zero_pin(i0), .ext_irq_one_pin(i1),
        .timer_zero_count_pin(c0), .timer_one_count_pin(c1), .ack_timer_zero(ack[0]),
        .ack_timer_one(ack[1]), .ack_ext_irq_zero(ack[2]), .ack_ext_irq_one(ack[3]),
        .timer_zero_overflow_flag_out(fl[0]), .timer_one_overflow_flag_out(fl[1]),
        .ext_irq_zero_flag_out(fl[2]), .ext_irq_one_flag_out(fl[3]), .irq(irq));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus transfer; waits for ready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] rq, output logic re);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("ready", 32'h0, 32'h1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00, q, e);
        chk(what, q, exp);
    endtask
    task automatic pulse_ack(input int i);
        @(posedge pclk);
        ack[i] <= 1'b1;
        @(posedge pclk);
        ack[i] <= 1'b0;
    endtask
    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctl reset", A_CTL, 32'h00);
        rd("mode reset", A_MODE, 32'h00);
        wr(A_MODE, 8'hA5);
        rd("mode rw", A_MODE, 32'hA5);
        wr(A_CTL, 8'hA5);
        rd("ctl rw", A_CTL, 32'hA5);
        chk("flag copies", {28'h0, fl}, 32'h3);
        pulse_ack(0);
        pulse_ack(1);
        rd("ctl acked", A_CTL, 32'h05);
        wr(A_CTL, 8'h00);
        apb(1'b0, A_CTL + 12'h001, 8'h00, q, e);
        chk("unaligned err", {31'h0, e}, 32'h1);
        apb(1'b0, 12'h300, 8'h00, q, e);
        chk("unmapped data", q, 32'h0);
        $display("test registers done");
        // Modes 0, 1, 2 each overflow within two internal ticks
        for (int m = 0; m < 3; m++) begin
            wr(A_CTL, 8'h00);
            wr(A_MODE, 8'(m));
            wr(A_TH0, 8'hFF);
            wr(A_TL0, tl_tab[m]);
            wr(A_CTL, 8'h10);
            repeat (40) @(posedge pclk);
            rd("ovf0 mode", A_CTL, 32'h30);
        end
        wr(A_CTL, 8'h00);
        wr(A_TL0, 8'hFF);
        repeat (40) @(posedge pclk);
        rd("low0 stopped", A_TL0, 32'hFF);
        wr(A_TL1, 8'hFE);
        wr(A_MODE, 8'h33);
        wr(A_TL0, 8'hFE);
        wr(A_CTL, 8'h50);
        repeat (40) @(posedge pclk);
        rd("split flags", A_CTL, 32'hF0);
        rd("low1 frozen", A_TL1, 32'hFE);
        $display("test modes done");
        wr(A_CTL, 8'h00);
        wr(A_MODE, 8'h06);
        wr(A_TH0, 8'hF0);
        wr(A_TL0, 8'hFD);
        wr(A_CTL, 8'h10);
        pins.pulses(2, 3);
        rd("reload", A_TL0, 32'hF0);
        rd("ovf0 count", A_CTL, 32'h30);
        wr(A_MODE, 8'h0E);
        wr(A_CTL, 8'h10);
        pins.drive(0, 1'b0);
        pins.pulses(2, 2);
        rd("gated", A_TL0, 32'hF0);
        rd("xf0 level", A_CTL, 32'h12);
        chk("xf0 copy", {28'h0, fl}, 32'h4);
        rd("status", A_STAT, 32'h07);
        pins.drive(0, 1'b1);
        rd("xf0 follows", A_CTL, 32'h10);
        $display("test counter done");
        wr(A_STAT, 8'h0F);
        rd("status clr", A_STAT, 32'h00);
        wr(A_CTL, 8'h04);
        wr(A_MASK, 8'h08);
        pins.drive(1, 1'b0);
        rd("xf1 edge", A_CTL, 32'h0C);
        chk("irq on", {31'h0, irq}, 32'h1);
        pulse_ack(3);
        rd("xf1 acked", A_CTL, 32'h04);
        wr(A_STAT, 8'h08);
        repeat (2) @(posedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        wr(A_MODE, 8'h90);
        wr(A_TH1, 8'hFF);
        wr(A_TL1, 8'hFE);
        wr(A_CTL, 8'h44);
        repeat (40) @(posedge pclk);
        rd("gate low", A_CTL, 32'h44);
        pins.drive(1, 1'b1);
        repeat (40) @(posedge pclk);
        rd("gate high", A_CTL, 32'hC4);
        wr(A_MODE, 8'h50);
        wr(A_TH1, 8'h00);
        wr(A_TL1, 8'hF0);
        pins.pulses(3, 2);
        rd("pin counter one", A_TL1, 32'hF2);
        $display("test timer one done");
        complete_run();
    end
endmodule
